// file: verilog/lcf_pkg.sv
// Package of offsets, field layouts, reset values and encodings for the link credit flow tracker.
package lcf_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_THRESH_OFS = 4'h0;
  localparam logic [3:0] REG_CTRL_OFS   = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h8;

  // ---------------------------------------------------------------
  // Threshold register fields and reset values
  // ---------------------------------------------------------------
  localparam int THR_REPORTED_LSB = 0;
  localparam int THR_LOWER_LSB    = 8;
  localparam int THR_MIDDLE_LSB   = 16;
  localparam int THR_UPPER_LSB    = 24;
  localparam logic [7:0] UPPER_RST  = 8'h04;
  localparam logic [7:0] MIDDLE_RST = 8'h03;
  localparam logic [7:0] LOWER_RST  = 8'h02;
  localparam logic [7:0] FIELD_MAX  = 8'h0e;

  // ---------------------------------------------------------------
  // Control and status fields
  // ---------------------------------------------------------------
  localparam int         CTRL_AUTO_BIT  = 0;
  localparam int         CTRL_TXSUP_BIT = 1;
  localparam logic [1:0] CTRL_RST       = 2'h3;
  localparam int STAT_MODE_BIT    = 0;
  localparam int STAT_SETTLED_BIT = 1;
  localparam int STAT_WAIT_BIT    = 2;
  localparam int STAT_FREE_LSB    = 8;
  localparam int STAT_OUT_LSB     = 16;

  // ---------------------------------------------------------------
  // Buffer-status values and received symbol kinds
  // ---------------------------------------------------------------
  localparam logic [3:0] BUF_MAX_REPORT = 4'he;
  localparam logic [3:0] BUF_RX_MODE    = 4'hf;
  localparam logic [2:0] SYM_IDLE   = 3'h0;
  localparam logic [2:0] SYM_ACCEPT = 3'h1;
  localparam logic [2:0] SYM_RETRY  = 3'h2;
  localparam logic [2:0] SYM_NACK   = 3'h3;
  localparam logic [2:0] SYM_LRESP  = 3'h4;
  localparam logic [2:0] SYM_OTHER  = 3'h5;

  typedef enum logic [1:0] {
    LCF_LINK_DOWN,
    LCF_NEGOTIATE,
    LCF_RUN,
    LCF_WAIT_RESP
  } lcf_state_e;

endpackage : lcf_pkg

// file: verilog/lcf_tracker.sv
// Transmit-side credit and flow-control mode tracker for one packet link port.
`timescale 1ns/1ns
`default_nettype none

module lcf_tracker #(
  parameter int OUT_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              link_clk,
  input  wire logic              link_up,
  input  wire logic              sym_valid,
  input  wire logic [2:0]        sym_kind,
  input  wire logic [3:0]        sym_buf_status,
  input  wire logic              pkt_sent,
  input  wire logic [3:0]        local_free_bufs,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic                   tx_ctrl_mode,
  output logic                   mode_settled,
  output logic      [3:0]        free_count,
  output logic      [OUT_W-1:0]  outstanding_count,
  output logic      [3:0]        prio_allowed,
  output logic                   link_req_send,
  output logic      [3:0]        adv_buf_status
);
  import lcf_pkg::*;

  // ---------------------------------------------------------------
  // Link-side synchronisers
  // ---------------------------------------------------------------
  // The link clock is sampled like data; its rising edge, seen after the
  // same two-stage delay as the symbol fields, marks when they are stable.
  logic       lclk_s1, lclk_s2, lclk_s3;
  logic       up_s1, up_s2;
  logic       vld_s1, vld_s2;
  logic [2:0] kind_s1, kind_s2;
  logic [3:0] bs_s1, bs_s2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      up_s1   <= 1'b0;
      up_s2   <= 1'b0;
      vld_s1  <= 1'b0;
      vld_s2  <= 1'b0;
      kind_s1 <= 3'h0;
      kind_s2 <= 3'h0;
      bs_s1   <= 4'h0;
      bs_s2   <= 4'h0;
    end else begin
      lclk_s1 <= link_clk;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      up_s1   <= link_up;
      up_s2   <= up_s1;
      vld_s1  <= sym_valid;
      vld_s2  <= vld_s1;
      kind_s1 <= sym_kind;
      kind_s2 <= kind_s1;
      bs_s1   <= sym_buf_status;
      bs_s2   <= bs_s1;
    end
  end

  logic sym_evt;
  assign sym_evt = lclk_s2 & ~lclk_s3 & vld_s2;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] sat_sub(input logic [3:0] bs, input logic [OUT_W-1:0] cnt);
    if (cnt >= OUT_W'(bs)) begin
      sat_sub = 4'h0;
    end else begin
      sat_sub = bs - cnt[3:0];
    end
  endfunction : sat_sub

  function automatic logic [7:0] clamp_field(input logic [7:0] v);
    clamp_field = (v > FIELD_MAX) ? FIELD_MAX : v;
  endfunction : clamp_field

  // ---------------------------------------------------------------
  // Tracker state
  // ---------------------------------------------------------------
  lcf_state_e       state_reg, state_next;
  logic             mode_reg, mode_next;
  logic             settled_reg, settled_next;
  logic [3:0]       free_reg, free_next;
  logic [OUT_W-1:0] out_reg, out_next;
  logic [7:0]       upper_reg, upper_next;
  logic [7:0]       middle_reg, middle_next;
  logic [7:0]       lower_reg, lower_next;
  logic [7:0]       reported_reg, reported_next;
  logic [1:0]       ctrl_reg, ctrl_next;
  logic [3:0]       prio_reg, prio_next;
  logic             lreq_reg, lreq_next;
  logic [3:0]       adv_reg, adv_next;
  logic [31:0]      rdata_reg, rdata_next;

  always_comb begin
    logic [OUT_W-1:0] dec_cnt;
    logic [7:0]       up_d;
    logic [3:0]       cap_local;
    dec_cnt       = (out_reg == '0) ? '0 : out_reg - OUT_W'(1);
    up_d          = 8'h0;
    cap_local     = 4'h0;
    state_next    = state_reg;
    mode_next     = mode_reg;
    settled_next  = settled_reg;
    free_next     = free_reg;
    out_next      = out_reg;
    upper_next    = upper_reg;
    middle_next   = middle_reg;
    lower_next    = lower_reg;
    reported_next = reported_reg;
    ctrl_next     = ctrl_reg;
    lreq_next     = 1'b0;
    rdata_next    = 32'h0;

    if (reg_wr) begin
      case (reg_addr)
        REG_THRESH_OFS: begin
          upper_next  = clamp_field(reg_wdata[THR_UPPER_LSB +: 8]);
          middle_next = clamp_field(reg_wdata[THR_MIDDLE_LSB +: 8]);
          lower_next  = clamp_field(reg_wdata[THR_LOWER_LSB +: 8]);
        end
        REG_CTRL_OFS: ctrl_next = reg_wdata[1:0];
        default: ;
      endcase
    end

    if (!up_s2) begin
      // Link initialisation is the reset point of all credit state.
      state_next   = LCF_LINK_DOWN;
      mode_next    = 1'b0;
      settled_next = 1'b0;
      free_next    = 4'h0;
      out_next     = '0;
    end else begin
      case (state_reg)
        LCF_LINK_DOWN: state_next = LCF_NEGOTIATE;
        LCF_NEGOTIATE: begin
          if (sym_evt && kind_s2 == SYM_IDLE) begin
            reported_next = {4'h0, bs_s2};
            settled_next  = 1'b1;
            state_next    = LCF_RUN;
            if (bs_s2 < BUF_RX_MODE && ctrl_reg[CTRL_TXSUP_BIT]) begin
              mode_next = 1'b1;
              free_next = bs_s2;
              out_next  = '0;
              if (ctrl_reg[CTRL_AUTO_BIT]) begin
                // Fit the thresholds at or under the reported count (upper at most 4), but for a
                // partner reporting under 3 use 3/2/1 to keep them distinct and nonzero.
                up_d        = (bs_s2 > 4'h4) ? UPPER_RST :
                              (bs_s2 < 4'h3) ? MIDDLE_RST : {4'h0, bs_s2};
                upper_next  = up_d;
                middle_next = up_d - 8'h01;
                lower_next  = up_d - 8'h02;
              end
            end else begin
              mode_next = 1'b0;
            end
          end else if (pkt_sent) begin
            // A packet that goes before any idle status settles on receiver mode.
            settled_next = 1'b1;
            mode_next    = 1'b0;
            state_next   = LCF_RUN;
          end
        end
        LCF_RUN: begin
          if (sym_evt && mode_reg) begin
            case (kind_s2)
              SYM_ACCEPT: begin
                out_next  = dec_cnt;
                free_next = sat_sub(bs_s2, dec_cnt);
              end
              SYM_RETRY: begin
                out_next  = '0;
                free_next = bs_s2;
              end
              SYM_NACK: begin
                out_next   = '0;
                free_next  = 4'h0;
                lreq_next  = 1'b1;
                state_next = LCF_WAIT_RESP;
              end
              default: free_next = sat_sub(bs_s2, out_reg);
            endcase
          end
        end
        LCF_WAIT_RESP: begin
          // Status from other symbols is ignored until the response arrives.
          if (sym_evt && kind_s2 == SYM_LRESP) begin
            free_next  = bs_s2;
            state_next = LCF_RUN;
          end
        end
        default: state_next = LCF_LINK_DOWN;
      endcase
      // Sends are counted even past the free count; excess ones are speculative.
      if (pkt_sent && state_reg != LCF_LINK_DOWN && out_next != '1) begin
        out_next = out_next + OUT_W'(1);
      end
    end

    // Monotonic mask: a lower priority is never allowed where a higher is not.
    if (!mode_next) begin
      prio_next = 4'hf;
    end else if ({4'h0, free_next} >= upper_next) begin
      prio_next = 4'hf;
    end else if ({4'h0, free_next} >= middle_next) begin
      prio_next = 4'he;
    end else if ({4'h0, free_next} >= lower_next) begin
      prio_next = 4'hc;
    end else begin
      prio_next = 4'h8;
    end

    cap_local = (local_free_bufs > BUF_MAX_REPORT) ? BUF_MAX_REPORT : local_free_bufs;
    if (ctrl_next[CTRL_TXSUP_BIT] && (mode_next || !settled_next)) begin
      adv_next = cap_local;
    end else begin
      adv_next = BUF_RX_MODE;
    end

    if (reg_rd) begin
      case (reg_addr)
        REG_THRESH_OFS: rdata_next = {upper_reg, middle_reg, lower_reg, reported_reg};
        REG_CTRL_OFS:   rdata_next = {30'h0, ctrl_reg};
        REG_STATUS_OFS: begin
          rdata_next[STAT_MODE_BIT]           = mode_reg;
          rdata_next[STAT_SETTLED_BIT]        = settled_reg;
          rdata_next[STAT_WAIT_BIT]           = (state_reg == LCF_WAIT_RESP);
          rdata_next[STAT_FREE_LSB +: 4]      = free_reg;
          rdata_next[STAT_OUT_LSB +: OUT_W]   = out_reg;
        end
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= LCF_LINK_DOWN;
      mode_reg     <= 1'b0;
      settled_reg  <= 1'b0;
      free_reg     <= 4'h0;
      out_reg      <= '0;
      upper_reg    <= UPPER_RST;
      middle_reg   <= MIDDLE_RST;
      lower_reg    <= LOWER_RST;
      reported_reg <= 8'h0;
      ctrl_reg     <= CTRL_RST;
      prio_reg     <= 4'hf;
      lreq_reg     <= 1'b0;
      adv_reg      <= BUF_RX_MODE;
      rdata_reg    <= 32'h0;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      settled_reg  <= settled_next;
      free_reg     <= free_next;
      out_reg      <= out_next;
      upper_reg    <= upper_next;
      middle_reg   <= middle_next;
      lower_reg    <= lower_next;
      reported_reg <= reported_next;
      ctrl_reg     <= ctrl_next;
      prio_reg     <= prio_next;
      lreq_reg     <= lreq_next;
      adv_reg      <= adv_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign tx_ctrl_mode      = mode_reg;
  assign mode_settled      = settled_reg;
  assign free_count        = free_reg;
  assign outstanding_count = out_reg;
  assign prio_allowed      = prio_reg;
  assign link_req_send     = lreq_reg;
  assign adv_buf_status    = adv_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_prio_all_open: assert property (
                     mode_reg && {4'h0, free_reg} >= upper_reg |-> prio_reg == 4'hf)
    else $error("all priorities not open at top credit");
  a_prio_mid_band: assert property (mode_reg && {4'h0, free_reg} < upper_reg
                     && {4'h0, free_reg} >= middle_reg |-> prio_reg == 4'he)
    else $error("middle band mask wrong");
  a_prio_low_band: assert property (mode_reg && {4'h0, free_reg} < middle_reg
                     && {4'h0, free_reg} >= lower_reg |-> prio_reg == 4'hc)
    else $error("low band mask wrong");
  a_prio_floor_band: assert property (mode_reg && {4'h0, free_reg} < lower_reg
                       |-> prio_reg == 4'h8)
    else $error("floor band mask wrong");
  a_nack_clears: assert property (
                   state_reg == LCF_RUN && mode_reg && up_s2 && sym_evt
                   && kind_s2 == SYM_NACK && !pkt_sent
                   |=> free_reg == 4'h0 && out_reg == '0 && link_req_send
                   ##1 !link_req_send)
    else $error("not-accepted did not clear credit and request status");
  a_retry_loads: assert property (
                   state_reg == LCF_RUN && mode_reg && up_s2 && sym_evt
                   && kind_s2 == SYM_RETRY |=> free_reg == $past(bs_s2))
    else $error("retry did not load reported count");
  a_send_counts: assert property (
                   state_reg == LCF_RUN && up_s2 && pkt_sent && !sym_evt
                   && out_reg != '1 |=> out_reg == $past(out_reg) + OUT_W'(1))
    else $error("sent packet not counted");
  a_accept_drops: assert property (
                    state_reg == LCF_RUN && mode_reg && up_s2 && sym_evt
                    && kind_s2 == SYM_ACCEPT && !pkt_sent && out_reg != '0
                    |=> out_reg == $past(out_reg) - OUT_W'(1))
    else $error("accepted packet not taken off the count");
  // Only the link-response may refill credit after a rejected packet.
  a_wait_holds: assert property (
                  state_reg == LCF_WAIT_RESP && up_s2 && !(sym_evt && kind_s2 == SYM_LRESP)
                  |=> free_reg == $past(free_reg))
    else $error("credit changed while waiting for link-response");
  a_rx_negotiate: assert property (
                    state_reg == LCF_NEGOTIATE && up_s2 && sym_evt && kind_s2 == SYM_IDLE
                    && (bs_s2 == BUF_RX_MODE || !ctrl_reg[CTRL_TXSUP_BIT])
                    |=> mode_settled && !tx_ctrl_mode)
    else $error("receiver mode not chosen when one end lacks support");
  a_rx_all_ones: assert property (settled_reg && !mode_reg
                   |-> adv_buf_status == BUF_RX_MODE)
    else $error("receiver mode must advertise all ones");
  a_adv_capped: assert property (adv_buf_status != BUF_RX_MODE
                  |-> adv_buf_status <= $past(local_free_bufs))
    else $error("advertised more buffers than held");
  a_rdata_one_shot: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data stood longer than one cycle");

  c_tx_mode: cover property (!mode_reg ##1 mode_reg);
  c_nack_resp: cover property (state_reg == LCF_WAIT_RESP ##[1:200] state_reg == LCF_RUN);
  c_retry: cover property (sym_evt && kind_s2 == SYM_RETRY && mode_reg);
  c_floor: cover property (mode_reg && prio_reg == 4'h8);
  c_speculative: cover property (mode_reg && out_reg > OUT_W'(free_reg));

endmodule : lcf_tracker

`default_nettype wire

// file: tb/lcf_partner.sv
// Behavioural link partner that clocks one control symbol per link clock frame.
`timescale 1ns/1ns
`default_nettype none

module lcf_partner #(
  parameter int HALF_NS = 80
) (
  output var logic       link_clk,
  output var logic       sym_valid,
  output var logic [2:0] sym_kind,
  output var logic [3:0] sym_buf_status
);
  import lcf_pkg::*;

  // ---------------------------------------------------------------
  // Idle lines
  // ---------------------------------------------------------------
  // The clock stands still between frames, and released symbol lines carry the inverse
  // of the last value so that a late sample can never match by luck.
  initial begin
    link_clk       = 1'b0;
    sym_valid      = 1'b0;
    sym_kind       = 3'h0;
    sym_buf_status = 4'h0;
  end

  // ---------------------------------------------------------------
  // Symbol framing
  // ---------------------------------------------------------------
  // Each accept sent through here answers exactly one packet; a retry or not-accepted answers all outstanding.
  task automatic send(input logic [2:0] kind, input logic [3:0] bs);
    sym_valid      <= 1'b1;
    sym_kind       <= kind;
    sym_buf_status <= bs;
    #(HALF_NS) link_clk <= 1'b1;
    #(HALF_NS) link_clk <= 1'b0;
    sym_valid      <= 1'b0;
    sym_kind       <= ~kind;
    sym_buf_status <= ~bs;
    #(HALF_NS);
  endtask : send

  // Idle status announces the supported mode and never overstates real buffers.
  task automatic send_idle(input logic [3:0] bufs, input logic tx_ok);
    logic [3:0] bs;
    bs = !tx_ok ? BUF_RX_MODE :
         (bufs > BUF_MAX_REPORT ? BUF_MAX_REPORT : bufs);
    send(SYM_IDLE, bs);
  endtask : send_idle

endmodule : lcf_partner
`default_nettype wire

// file: tb/tb_lcf_tracker.sv
// Self-checking bench for the link credit flow tracker.
`timescale 1ns/1ns
`default_nettype none

module tb_lcf_tracker;
  import lcf_pkg::*;

  logic        clk             = 1'b0;
  logic        rst_n           = 1'b0;
  logic        link_up         = 1'b0;
  logic        pkt_sent        = 1'b0;
  logic [3:0]  local_free_bufs = 4'h9;
  logic [3:0]  reg_addr        = 4'h0;
  logic [31:0] reg_wdata       = 32'h0;
  logic        reg_wr          = 1'b0;
  logic        reg_rd          = 1'b0;
  logic        link_clk;
  logic        sym_valid;
  logic [2:0]  sym_kind;
  logic [3:0]  sym_buf_status;
  logic [31:0] reg_rdata;
  logic        tx_ctrl_mode;
  logic        mode_settled;
  logic [3:0]  free_count;
  logic [7:0]  outstanding_count;
  logic [3:0]  prio_allowed;
  logic        link_req_send;
  logic [3:0]  adv_buf_status;
  int          bad_count       = 0;
  int          check_count     = 0;
  int          req_count       = 0;
  int          base;

  lcf_tracker #(.OUT_W(8)) lcf_tracker_i (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_up(link_up),
    .sym_valid(sym_valid), .sym_kind(sym_kind), .sym_buf_status(sym_buf_status),
    .pkt_sent(pkt_sent), .local_free_bufs(local_free_bufs), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_ctrl_mode(tx_ctrl_mode), .mode_settled(mode_settled), .free_count(free_count),
    .outstanding_count(outstanding_count), .prio_allowed(prio_allowed),
    .link_req_send(link_req_send), .adv_buf_status(adv_buf_status)
  );

  lcf_partner lcf_partner_i (
    .link_clk(link_clk), .sym_valid(sym_valid), .sym_kind(sym_kind),
    .sym_buf_status(sym_buf_status)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // The request pulse lasts one cycle, so it is counted rather than polled.
  always @(posedge clk) begin
    if (link_req_send === 1'b1) begin
      req_count <= req_count + 1;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] addr, input logic [31:0] data);
    @(posedge clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic rd_check(input logic [3:0] addr, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge clk);
    #1;
    check(reg_rdata, 32'h0);
  endtask : rd_check

  task automatic sym(input logic [2:0] kind, input logic [3:0] bs);
    lcf_partner_i.send(kind, bs);
    #1;
  endtask : sym

  task automatic idle(input logic [3:0] bufs, input logic tx_ok);
    lcf_partner_i.send_idle(bufs, tx_ok);
    #1;
  endtask : idle

  task automatic pkts(input int n);
    repeat (n) begin
      @(posedge clk);
      pkt_sent <= 1'b1;
    end
    @(posedge clk);
    pkt_sent <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pkts

  task automatic expect_state(input logic [3:0] f, input logic [7:0] o, input logic [3:0] p);
    check({28'h0, free_count}, {28'h0, f});
    check({24'h0, outstanding_count}, {24'h0, o});
    check({28'h0, prio_allowed}, {28'h0, p});
  endtask : expect_state

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd_check(REG_THRESH_OFS, 32'h04030200);
    rd_check(REG_CTRL_OFS, 32'h00000003);
    rd_check(4'hc, 32'h00000000);
    check({28'h0, adv_buf_status}, 32'h9);
    @(posedge clk);
    local_free_bufs <= 4'hf;
    repeat (3) @(posedge clk);
    #1;
    check({28'h0, adv_buf_status}, 32'he);
    reg_write(REG_THRESH_OFS, 32'h0f0a05ff);
    rd_check(REG_THRESH_OFS, 32'h0e0a0500);
    @(posedge clk);
    link_up <= 1'b1;
    repeat (6) @(posedge clk);
    idle(4'h6, 1'b1);
    check({30'h0, mode_settled, tx_ctrl_mode}, 32'h3);
    expect_state(4'h6, 8'h00, 4'hf);
    rd_check(REG_THRESH_OFS, 32'h04030206);
    rd_check(REG_STATUS_OFS, 32'h00000603);
    pkts(3);
    expect_state(4'h6, 8'h03, 4'hf);
    sym(SYM_IDLE, 4'h6);
    expect_state(4'h3, 8'h03, 4'he);
    sym(SYM_ACCEPT, 4'h5);
    expect_state(4'h3, 8'h02, 4'he);
    sym(SYM_ACCEPT, 4'h3);
    expect_state(4'h2, 8'h01, 4'hc);
    sym(SYM_OTHER, 4'h2);
    expect_state(4'h1, 8'h01, 4'h8);
    pkts(3);
    sym(SYM_OTHER, 4'h2);
    expect_state(4'h0, 8'h04, 4'h8);
    sym(SYM_RETRY, 4'h9);
    expect_state(4'h9, 8'h00, 4'hf);
    pkts(2);
    base = req_count;
    sym(SYM_NACK, 4'h7);
    expect_state(4'h0, 8'h00, 4'h8);
    check(32'(req_count - base), 32'h1);
    rd_check(REG_STATUS_OFS, 32'h00000007);
    sym(SYM_IDLE, 4'h9);
    expect_state(4'h0, 8'h00, 4'h8);
    sym(SYM_LRESP, 4'h7);
    expect_state(4'h7, 8'h00, 4'hf);
    // Either end lacking transmitter support must leave both in receiver mode.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      link_up <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      expect_state(4'h0, 8'h00, 4'hf);
      reg_write(REG_CTRL_OFS, (i == 0) ? 32'h3 : 32'h1);
      link_up <= 1'b1;
      repeat (6) @(posedge clk);
      idle(4'h6, i[0]);
      check({30'h0, mode_settled, tx_ctrl_mode}, 32'h2);
      check({28'h0, adv_buf_status}, 32'hf);
    end
    // Derivation off: software thresholds survive a fresh negotiation.
    @(posedge clk);
    link_up <= 1'b0;
    reg_write(REG_CTRL_OFS, 32'h2);
    reg_write(REG_THRESH_OFS, 32'h0c080600);
    link_up <= 1'b1;
    repeat (6) @(posedge clk);
    idle(4'h2, 1'b1);
    check({30'h0, mode_settled, tx_ctrl_mode}, 32'h3);
    check({28'h0, adv_buf_status}, 32'he);
    expect_state(4'h2, 8'h00, 4'h8);
    rd_check(REG_THRESH_OFS, 32'h0c080602);
    // A packet sent before any idle status settles on receiver mode.
    @(posedge clk);
    link_up <= 1'b0;
    repeat (6) @(posedge clk);
    link_up <= 1'b1;
    repeat (6) @(posedge clk);
    pkts(1);
    idle(4'h6, 1'b1);
    check({30'h0, mode_settled, tx_ctrl_mode}, 32'h2);
    expect_state(4'h0, 8'h01, 4'hf);
    stop_test();
  end

  initial begin
    #500000;
    bad_count++;
    stop_test();
  end

endmodule : tb_lcf_tracker
`default_nettype wire
